// File: common/uart_intfifo_params.svh
// Purpose: offsets, field positions, reset values and codes of the UART interrupt/FIFO block
// Assumes: included by design files by bare name
// Notes: definitions only
//
// Behaviour
// - Registers decode at byte offsets from a software-set base, one base per instance.
// - Interrupt-enable bit 3 set: interrupt on any modem status change.
// - Interrupt-enable bit 2 set: interrupt on any receiver line status change.
// - Interrupt-enable bit 1 set: interrupt when transmit holding buffer becomes empty.
// - Interrupt-enable bit 0 set: interrupt while receive register holds data, or while FIFO holds its trigger level.
// - Ident bits 7:6 give FIFO state: 00 none, 01 unusable, 10 reserved, 11 enabled.
// - Ident bits 2:1 give source: 00 modem, 01 tx empty, 10 rx data, 11 line.
// - Priority: line status, then rx data, then tx empty, modem status last.
// - Ident bit 0 reads 0 while an enabled interrupt pends, 1 otherwise.
// - FIFO control bits 7:6 pick rx trigger level: 1, 4, 8 or 14 bytes.
// - Writing 1 to FIFO control bit 1 empties the receive FIFO.
// - Writing 1 to FIFO control bit 2 empties the transmit FIFO likewise.
// - A FIFO clear discards FIFO contents only, never the shift register.
// - Both FIFO clear bits return to 0 by themselves after acting.
// - FIFO control bit 0 enables both FIFOs; writing 0 disables and discards data.
// - After reset FIFO control holds 14-byte trigger with FIFOs enabled.
// - Interrupt-enable location acts as register only while divisor latch bit is 0.
`ifndef UART_INTFIFO_PARAMS_SVH
`define UART_INTFIFO_PARAMS_SVH

// Register offsets within the 8-byte window
`define OFS_INT_ENABLE 3'h1
`define OFS_INT_IDENT 3'h2
`define OFS_FIFO_CONTROL 3'h2

// Interrupt enable fields and reset
`define IER_MODEM_BIT 3
`define IER_LINE_BIT 2
`define IER_THRE_BIT 1
`define IER_RXDATA_BIT 0
`define IER_RESET 4'h0

// FIFO control fields and reset
`define FCR_TRIG_HI 7
`define FCR_TRIG_LO 6
`define FCR_TX_CLR_BIT 2
`define FCR_RX_CLR_BIT 1
`define FCR_ENABLE_BIT 0
`define FCR_RESET 8'hc1

// Identification codes
`define FIFO_ST_NONE 2'h0
`define FIFO_ST_ON 2'h3
`define ID_MODEM 2'h0
`define ID_THRE 2'h1
`define ID_RXDATA 2'h2
`define ID_LINE 2'h3

// Trigger levels in bytes
`define TRIG_CODE_1 2'h0
`define TRIG_CODE_4 2'h1
`define TRIG_CODE_8 2'h2
`define TRIG_BYTES_1 5'h01
`define TRIG_BYTES_4 5'h04
`define TRIG_BYTES_8 5'h08
`define TRIG_BYTES_14 5'h0e

`endif

// File: common/uart_intfifo_pkg.sv
// Purpose: state types of the UART interrupt/FIFO block
// Assumes: nothing beyond the params header
// Notes: one packed struct per stateful module
package uart_intfifo_pkg;

  // FIFO control state
  typedef struct packed {
    logic en;
    logic [1:0] trig;
    logic rx_clr;
    logic tx_clr;
  } fcr_state_t;

  // Top-level state
  typedef struct packed {
    logic [3:0] interrupt_enable;
    logic line_pend;
    logic modem_pend;
    logic thre_pend;
    logic thre_prev;
    logic [7:0] rdata;
  } top_state_t;

endpackage : uart_intfifo_pkg

// File: common/uart_ctl_if.sv
// Purpose: carrier between the top and its priority and FIFO-control leaves
// Assumes: one clock domain
// Notes: pend order is {line, rxdata, thre, modem}
`timescale 1ns/100ps
interface uart_ctl_if;
  logic [3:0] pend;
  logic [1:0] id;
  logic none;
  logic wr;
  logic [7:0] wdata;
  logic en;
  logic [1:0] trig;
  logic rx_clr;
  logic tx_clr;

  modport top_p (output pend, wr, wdata, input id, none, en, trig, rx_clr, tx_clr);
  modport prio_p (input pend, output id, none);
  modport fcr_p (input wr, wdata, output en, trig, rx_clr, tx_clr);
endinterface : uart_ctl_if

// File: hw/uart_int_prio.sv
// Purpose: picks the highest-priority enabled pending source
// Assumes: pend already gated by the enables
// Notes: pure combinational, no state
`timescale 1ns/100ps
`include "uart_intfifo_params.svh"
module uart_int_prio (
  // Carrier
  uart_ctl_if.prio_p ctl
);

  // Priority encode and pending flag
  always_comb begin
    ctl.none = (ctl.pend == 4'h0);
    ctl.id = `ID_MODEM;
    if (ctl.pend[3]) begin
      ctl.id = `ID_LINE;
    end else if (ctl.pend[2]) begin
      ctl.id = `ID_RXDATA;
    end else if (ctl.pend[1]) begin
      ctl.id = `ID_THRE;
    end
  end

endmodule : uart_int_prio

// File: hw/uart_fifo_ctl.sv
// Purpose: FIFO control register with self-clearing clear pulses
// Assumes: wr is a one-cycle strobe with wdata valid
// Notes: clear pulses last exactly one cycle
`timescale 1ns/100ps
`include "uart_intfifo_params.svh"
module uart_fifo_ctl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Carrier
  uart_ctl_if.fcr_p ctl
);

  uart_intfifo_pkg::fcr_state_t s_q;
  uart_intfifo_pkg::fcr_state_t s_d;
  // Reset image of the register; fields are sliced from it
  localparam logic [7:0] fcr_rst_val = `FCR_RESET;

  // Next state of the FIFO control
  always_comb begin
    s_d = s_q;
    s_d.rx_clr = 1'b0;
    s_d.tx_clr = 1'b0;
    if (ctl.wr) begin
      s_d.en = ctl.wdata[`FCR_ENABLE_BIT];
      s_d.trig = ctl.wdata[`FCR_TRIG_HI:`FCR_TRIG_LO];
      // Disabling drops both FIFOs
      s_d.rx_clr = ctl.wdata[`FCR_RX_CLR_BIT] | (s_q.en & ~ctl.wdata[`FCR_ENABLE_BIT]);
      s_d.tx_clr = ctl.wdata[`FCR_TX_CLR_BIT] | (s_q.en & ~ctl.wdata[`FCR_ENABLE_BIT]);
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q.en <= fcr_rst_val[`FCR_ENABLE_BIT];
      s_q.trig <= fcr_rst_val[`FCR_TRIG_HI:`FCR_TRIG_LO];
      s_q.rx_clr <= 1'b0;
      s_q.tx_clr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs from flops
  assign ctl.en = s_q.en;
  assign ctl.trig = s_q.trig;
  assign ctl.rx_clr = s_q.rx_clr;
  assign ctl.tx_clr = s_q.tx_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_one_pulse_rx;
    ctl.rx_clr ##1 (!ctl.rx_clr || $past(ctl.wr));
  endsequence

  property p_rx_clear;
    @(posedge clk_sys) disable iff (rst)
      ctl.wr && ctl.wdata[`FCR_RX_CLR_BIT] |=> s_one_pulse_rx;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx clear pulse wrong");

  property p_tx_clear;
    @(posedge clk_sys) disable iff (rst)
      ctl.wr && ctl.wdata[`FCR_TX_CLR_BIT] |=> ctl.tx_clr ##1 (!ctl.tx_clr || $past(ctl.wr));
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx clear pulse wrong");

  property p_disable_drops;
    @(posedge clk_sys) disable iff (rst)
      ctl.wr && ctl.en && !ctl.wdata[`FCR_ENABLE_BIT] |=> ctl.rx_clr && ctl.tx_clr && !ctl.en;
  endproperty
  a_disable_drops: assert property (p_disable_drops) else $error("disable kept data");

  property p_clear_self_ends;
    @(posedge clk_sys) disable iff (rst)
      ctl.rx_clr && !$past(ctl.wr) |-> 1'b0;
  endproperty
  a_clear_self_ends: assert property (p_clear_self_ends) else $error("clear not self ending");

endmodule : uart_fifo_ctl

// File: hw/uart_intfifo_top.sv
// Purpose: interrupt enable, identification and FIFO control of one UART instance
// Assumes: I/O strobes are one-cycle pulses synchronous to clk_sys
// Notes: read data appears one cycle after io_rd; other offsets belong to sibling blocks
`timescale 1ns/100ps
`include "uart_intfifo_params.svh"
module uart_intfifo_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Processor I/O port
  input wire logic [15:0] io_base,
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_hit,
  // Line control from sibling block
  input wire logic divisor_latch_access_bit,
  // Interrupt sources
  input wire logic modem_change,
  input wire logic modem_status_read,
  input wire logic line_event,
  input wire logic line_status_read,
  input wire logic thr_empty,
  input wire logic thr_write,
  input wire logic [4:0] rx_count,
  // Interrupt and FIFO control outputs
  output logic irq,
  output logic fifo_enable,
  output logic rx_fifo_clear,
  output logic tx_fifo_clear
);

  uart_ctl_if ctl ();
  uart_intfifo_pkg::top_state_t s_q;
  uart_intfifo_pkg::top_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Match one offset within the window above the base
  function automatic logic at_offset(input logic [15:0] addr, input logic [15:0] base,
                                     input logic [2:0] ofs);
    at_offset = (addr[15:3] == base[15:3]) && (addr[2:0] == ofs);
  endfunction : at_offset

  // Trigger code to byte count
  function automatic logic [4:0] trig_bytes(input logic [1:0] code);
    unique case (code)
      `TRIG_CODE_1: trig_bytes = `TRIG_BYTES_1;
      `TRIG_CODE_4: trig_bytes = `TRIG_BYTES_4;
      `TRIG_CODE_8: trig_bytes = `TRIG_BYTES_8;
      default: trig_bytes = `TRIG_BYTES_14;
    endcase
  endfunction : trig_bytes

  logic ier_sel;
  logic shared_sel;
  logic ier_wr;
  logic ier_rd;
  logic iir_rd;
  logic rx_ready;
  logic thre_rise;
  logic thre_clr;
  logic [7:0] iir_val;

  // Address decode; enable location yields to divisor latch
  assign ier_sel = at_offset(io_addr, io_base, `OFS_INT_ENABLE) & ~divisor_latch_access_bit;
  assign shared_sel = at_offset(io_addr, io_base, `OFS_INT_IDENT);
  assign ier_wr = io_wr & ier_sel;
  assign ier_rd = io_rd & ier_sel;
  assign iir_rd = io_rd & shared_sel;
  assign ctl.wr = io_wr & shared_sel;
  assign ctl.wdata = io_wdata;
  assign io_hit = (io_rd | io_wr) & (ier_sel | shared_sel);

  ////////////////////////////////////////////////////////////////////////////
  // Source conditions

  // Receive data ready: trigger level in FIFO mode, any byte otherwise
  assign rx_ready = ctl.en ? (rx_count >= trig_bytes(ctl.trig)) : (rx_count != 5'h00);

  // Holding buffer went empty, or enable turned on while empty
  assign thre_rise = (thr_empty & ~s_q.thre_prev) |
                     (ier_wr & io_wdata[`IER_THRE_BIT] & ~s_q.interrupt_enable[`IER_THRE_BIT] & thr_empty);

  // Reading the ident while it shows tx empty acknowledges it
  assign thre_clr = thr_write | (iir_rd & ~ctl.none & (ctl.id == `ID_THRE));

  // Gated pending vector {line, rxdata, thre, modem}
  assign ctl.pend = {s_q.interrupt_enable[`IER_LINE_BIT] & s_q.line_pend,
                     s_q.interrupt_enable[`IER_RXDATA_BIT] & rx_ready,
                     s_q.interrupt_enable[`IER_THRE_BIT] & s_q.thre_pend,
                     s_q.interrupt_enable[`IER_MODEM_BIT] & s_q.modem_pend};

  // Identification value
  assign iir_val = {(ctl.en ? `FIFO_ST_ON : `FIFO_ST_NONE), 3'h0, ctl.id, ctl.none};

  ////////////////////////////////////////////////////////////////////////////
  // Leaves

  uart_int_prio u_prio (
    .ctl(ctl)
  );

  uart_fifo_ctl u_fcr (
    .clk_sys(clk_sys),
    .rst(rst),
    .ctl(ctl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.thre_prev = thr_empty;
    // Sticky flags: set wins over clear
    s_d.modem_pend = modem_change | (s_q.modem_pend & ~modem_status_read);
    s_d.line_pend = line_event | (s_q.line_pend & ~line_status_read);
    s_d.thre_pend = thre_rise | (s_q.thre_pend & ~thre_clr);
    if (ier_wr) begin
      s_d.interrupt_enable = io_wdata[3:0];
    end
    if (ier_rd) begin
      s_d.rdata = {4'h0, s_q.interrupt_enable};
    end else if (iir_rd) begin
      s_d.rdata = iir_val;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q.interrupt_enable <= `IER_RESET;
      s_q.line_pend <= 1'b0;
      s_q.modem_pend <= 1'b0;
      s_q.thre_pend <= 1'b0;
      s_q.thre_prev <= 1'b0;
      s_q.rdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // FIFO clears act on the FIFO storage only; shift registers untouched
  assign rx_fifo_clear = ctl.rx_clr;
  assign tx_fifo_clear = ctl.tx_clr;
  assign fifo_enable = ctl.en;
  assign io_rdata = s_q.rdata;
  assign irq = ~ctl.none;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_ier_write;
    @(posedge clk_sys) disable iff (rst)
      ier_wr |=> s_q.interrupt_enable == $past(io_wdata[3:0]);
  endproperty
  a_ier_write: assert property (p_ier_write) else $error("enable write lost");

  property p_ier_divisor_latch_access_bit;
    @(posedge clk_sys) disable iff (rst)
      io_wr && divisor_latch_access_bit && io_addr[2:0] == `OFS_INT_ENABLE |=> $stable(s_q.interrupt_enable);
  endproperty
  a_ier_divisor_latch_access_bit: assert property (p_ier_divisor_latch_access_bit) else $error("enable changed under latch access");

  property p_modem_irq;
    @(posedge clk_sys) disable iff (rst)
      modem_change && s_q.interrupt_enable[`IER_MODEM_BIT] && !ier_wr |=> irq;
  endproperty
  a_modem_irq: assert property (p_modem_irq) else $error("modem change gave no interrupt");

  property p_line_first;
    @(posedge clk_sys) disable iff (rst)
      line_event && s_q.interrupt_enable[`IER_LINE_BIT] && !ier_wr |=> ctl.id == `ID_LINE && !ctl.none;
  endproperty
  a_line_first: assert property (p_line_first) else $error("line status not first");

  property p_rx_over_thre;
    @(posedge clk_sys) disable iff (rst)
      ctl.pend[2] && !ctl.pend[3] |-> ctl.id == `ID_RXDATA;
  endproperty
  a_rx_over_thre: assert property (p_rx_over_thre) else $error("rx data priority wrong");

  sequence s_thre_edge;
    thr_empty && !s_q.thre_prev && s_q.interrupt_enable[`IER_THRE_BIT] && !thr_write && !ier_wr;
  endsequence

  property p_thre_irq;
    @(posedge clk_sys) disable iff (rst)
      s_thre_edge |=> s_q.thre_pend && irq;
  endproperty
  a_thre_irq: assert property (p_thre_irq) else $error("tx empty gave no interrupt");

  property p_rx_data;
    @(posedge clk_sys) disable iff (rst)
      s_q.interrupt_enable[`IER_RXDATA_BIT] && !ctl.en && rx_count != 5'h00 |-> irq;
  endproperty
  a_rx_data: assert property (p_rx_data) else $error("rx data gave no interrupt");

  property p_ident_read;
    @(posedge clk_sys) disable iff (rst)
      iir_rd |=> io_rdata[7:6] == ($past(ctl.en) ? `FIFO_ST_ON : `FIFO_ST_NONE)
             && io_rdata[0] == $past(ctl.none) && io_rdata[2:1] == $past(ctl.id);
  endproperty
  a_ident_read: assert property (p_ident_read) else $error("ident read wrong");

  property p_pending_bit;
    @(posedge clk_sys) disable iff (rst)
      ctl.none == (ctl.pend == 4'h0);
  endproperty
  a_pending_bit: assert property (p_pending_bit) else $error("pending bit wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on decode, sticky flags, trigger levels and priority

  property p_hit_window;
    @(posedge clk_sys) disable iff (rst)
      io_hit |-> io_addr[15:3] == io_base[15:3];
  endproperty
  a_hit_window: assert property (p_hit_window) else $error("hit outside window");

  property p_hit_shared;
    @(posedge clk_sys) disable iff (rst)
      (io_rd || io_wr) && io_addr[15:3] == io_base[15:3] && io_addr[2:0] == `OFS_INT_IDENT
        |-> io_hit;
  endproperty
  a_hit_shared: assert property (p_hit_shared) else $error("shared offset missed");

  property p_ier_read;
    @(posedge clk_sys) disable iff (rst)
      ier_rd |=> io_rdata == {4'h0, $past(s_q.interrupt_enable)};
  endproperty
  a_ier_read: assert property (p_ier_read) else $error("enable read wrong");

  property p_rdata_hold;
    @(posedge clk_sys) disable iff (rst)
      !io_rd |=> $stable(io_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_modem_set;
    @(posedge clk_sys) disable iff (rst)
      modem_change |=> s_q.modem_pend;
  endproperty
  a_modem_set: assert property (p_modem_set) else $error("modem flag lost");

  property p_modem_clear;
    @(posedge clk_sys) disable iff (rst)
      modem_status_read && !modem_change |=> !s_q.modem_pend;
  endproperty
  a_modem_clear: assert property (p_modem_clear) else $error("modem flag kept");

  property p_line_set;
    @(posedge clk_sys) disable iff (rst)
      line_event |=> s_q.line_pend;
  endproperty
  a_line_set: assert property (p_line_set) else $error("line flag lost");

  property p_line_clear;
    @(posedge clk_sys) disable iff (rst)
      line_status_read && !line_event |=> !s_q.line_pend;
  endproperty
  a_line_clear: assert property (p_line_clear) else $error("line flag kept");

  property p_thre_write_clear;
    @(posedge clk_sys) disable iff (rst)
      thr_write && !thre_rise |=> !s_q.thre_pend;
  endproperty
  a_thre_write_clear: assert property (p_thre_write_clear) else $error("tx flag kept");

  property p_thre_ident_clear;
    @(posedge clk_sys) disable iff (rst)
      iir_rd && ctl.id == `ID_THRE && !ctl.none && !thre_rise |=> !s_q.thre_pend;
  endproperty
  a_thre_ident_clear: assert property (p_thre_ident_clear) else $error("tx ack lost");

  sequence s_thre_arm;
    ier_wr && io_wdata[`IER_THRE_BIT] && !s_q.interrupt_enable[`IER_THRE_BIT] && thr_empty;
  endsequence

  property p_thre_arm;
    @(posedge clk_sys) disable iff (rst)
      s_thre_arm |=> s_q.thre_pend && irq;
  endproperty
  a_thre_arm: assert property (p_thre_arm) else $error("tx enable gave no interrupt");

  property p_rx_fourteen;
    @(posedge clk_sys) disable iff (rst)
      ctl.en && s_q.interrupt_enable[`IER_RXDATA_BIT] && rx_count >= `TRIG_BYTES_14 |-> ctl.pend[2];
  endproperty
  a_rx_fourteen: assert property (p_rx_fourteen) else $error("full fifo no rx");

  property p_rx_one;
    @(posedge clk_sys) disable iff (rst)
      ctl.en && ctl.trig == `TRIG_CODE_1 && s_q.interrupt_enable[`IER_RXDATA_BIT] && rx_count != 5'h00
        |-> ctl.pend[2];
  endproperty
  a_rx_one: assert property (p_rx_one) else $error("one byte level wrong");

  property p_rx_four;
    @(posedge clk_sys) disable iff (rst)
      ctl.en && ctl.trig == `TRIG_CODE_4 && s_q.interrupt_enable[`IER_RXDATA_BIT]
        |-> ctl.pend[2] == (rx_count >= `TRIG_BYTES_4);
  endproperty
  a_rx_four: assert property (p_rx_four) else $error("four byte level wrong");

  property p_rx_eight;
    @(posedge clk_sys) disable iff (rst)
      ctl.en && ctl.trig == `TRIG_CODE_8 && s_q.interrupt_enable[`IER_RXDATA_BIT]
        |-> ctl.pend[2] == (rx_count >= `TRIG_BYTES_8);
  endproperty
  a_rx_eight: assert property (p_rx_eight) else $error("eight byte level wrong");

  property p_rx_no_fifo;
    @(posedge clk_sys) disable iff (rst)
      !ctl.en && rx_count == 5'h00 |-> !ctl.pend[2];
  endproperty
  a_rx_no_fifo: assert property (p_rx_no_fifo) else $error("rx with no data");

  property p_thre_prio;
    @(posedge clk_sys) disable iff (rst)
      ctl.pend[1] && ctl.pend[3:2] == 2'h0 |-> ctl.id == `ID_THRE;
  endproperty
  a_thre_prio: assert property (p_thre_prio) else $error("tx priority wrong");

  property p_modem_last;
    @(posedge clk_sys) disable iff (rst)
      ctl.pend == 4'h1 |-> ctl.id == `ID_MODEM && !ctl.none;
  endproperty
  a_modem_last: assert property (p_modem_last) else $error("modem priority wrong");

  property p_line_top;
    @(posedge clk_sys) disable iff (rst)
      ctl.pend[3] |-> ctl.id == `ID_LINE;
  endproperty
  a_line_top: assert property (p_line_top) else $error("line priority wrong");

  property p_ident_reserved;
    @(posedge clk_sys) disable iff (rst)
      iir_val[5:3] == 3'h0 && iir_val[7:6] != 2'h1;
  endproperty
  a_ident_reserved: assert property (p_ident_reserved) else $error("ident fields wrong");

  property p_irq_level;
    @(posedge clk_sys) disable iff (rst)
      irq == (ctl.pend != 4'h0);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

endmodule : uart_intfifo_top

// File: tb/uart_src_model.sv
// Purpose: far-side model of the rx and tx FIFOs feeding the block
// Assumes: push_rx is a one-cycle pulse from the bench
// Notes: transmit FIFO starts full so empty only rises on a clear
`timescale 1ns/100ps
module uart_src_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Stimulus and clears
  input wire logic push_rx,
  input wire logic rx_fifo_clear,
  input wire logic tx_fifo_clear,
  input wire logic thr_write,
  // Source levels
  output logic [4:0] rx_count,
  output logic thr_empty
);
  ////////////////////////////////////////////////////////////////////////////////
  // Byte count and holding-buffer level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_count <= 5'h00;
      thr_empty <= 1'b0;
    end else begin
      if (rx_fifo_clear) rx_count <= 5'h00;
      else if (push_rx && rx_count < 5'h10) rx_count <= rx_count + 5'h01;
      if (tx_fifo_clear) thr_empty <= 1'b1;
      else if (thr_write) thr_empty <= 1'b0;
    end
  end
endmodule : uart_src_model

// File: tb/uart_interrupt_fifo_control_tb_top.sv
// Purpose: self-checking bench of the interrupt and FIFO control block
// Assumes: strobes driven at the falling edge
// Notes: integer model predicts ident, irq and clear pulses
`timescale 1ns/100ps
module uart_interrupt_fifo_control_tb_top;
  logic clk_sys, rst, io_rd, io_wr, io_hit, irq, fifo_enable, rx_fifo_clear, tx_fifo_clear;
  logic divisor_latch_access_bit, modem_change, modem_status_read, line_event;
  logic line_status_read, thr_write, push_rx, thr_empty;
  logic [15:0] io_base, io_addr;
  logic [7:0] io_wdata, io_rdata, v;
  logic [4:0] rx_count;
  logic [31:0] lfsr;
  int err_count, total_checks, cyc, interrupt_enable, en, trig, line_p, modem_p, thre_p;
  int lv[4] = '{1, 4, 8, 14};

  uart_intfifo_top uart_intfifo_top_i (.clk_sys(clk_sys), .rst(rst), .io_base(io_base),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_hit(io_hit), .divisor_latch_access_bit(divisor_latch_access_bit),
    .modem_change(modem_change), .modem_status_read(modem_status_read),
    .line_event(line_event), .line_status_read(line_status_read), .thr_empty(thr_empty),
    .thr_write(thr_write), .rx_count(rx_count), .irq(irq), .fifo_enable(fifo_enable),
    .rx_fifo_clear(rx_fifo_clear), .tx_fifo_clear(tx_fifo_clear));
  uart_src_model uart_src_model_i (.clk_sys(clk_sys), .rst(rst), .push_rx(push_rx),
    .rx_fifo_clear(rx_fifo_clear), .tx_fifo_clear(tx_fifo_clear), .thr_write(thr_write),
    .rx_count(rx_count), .thr_empty(thr_empty));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [7:0] exp_id();
    logic [1:0] id;
    logic none;
    logic rxp;
    none = 1'b0;
    rxp = en ? (rx_count >= lv[trig]) : (rx_count != 5'h00);
    if (interrupt_enable[2] && line_p) id = 2'h3;
    else if (interrupt_enable[0] && rxp) id = 2'h2;
    else if (interrupt_enable[1] && thre_p) id = 2'h1;
    else if (interrupt_enable[3] && modem_p) id = 2'h0;
    else begin
      id = 2'h0;
      none = 1'b1;
    end
    return {(en ? 2'h3 : 2'h0), 3'h0, id, none};
  endfunction : exp_id
  // One strobe cycle; hit is checked while the strobe is up
  task automatic acc(input logic w, input logic [2:0] ofs, input logic [7:0] d,
                     input logic hit);
    @(negedge clk_sys);
    io_addr = io_base + {13'h0, ofs};
    io_wdata = d;
    io_rd = ~w;
    io_wr = w;
    #5 chk({7'h0, io_hit}, {7'h0, hit});
    @(negedge clk_sys);
    io_rd = 1'b0;
    io_wr = 1'b0;
  endtask : acc
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    @(negedge clk_sys);
  endtask : pulse
  task automatic chk_id();
    logic [7:0] e;
    logic [7:0] f;
    e = exp_id();
    acc(1'b0, 3'h2, 8'h00, 1'b1);
    chk(io_rdata, e);
    if (e[2:0] == 3'h2) thre_p = 0;
    // Reading a tx-empty ident drops it, so irq is judged afterwards
    f = exp_id();
    chk({7'h0, irq}, {7'h0, ~f[0]});
  endtask : chk_id
  task automatic wi(input logic [7:0] d);
    acc(1'b1, 3'h1, d, ~divisor_latch_access_bit);
    if (!divisor_latch_access_bit) begin
      if (!interrupt_enable[1] && d[1] && thr_empty) thre_p = 1;
      interrupt_enable = d[3:0];
    end
    acc(1'b0, 3'h1, 8'h00, ~divisor_latch_access_bit);
    if (!divisor_latch_access_bit) chk(io_rdata, interrupt_enable[7:0]);
  endtask : wi
  task automatic wf(input logic [7:0] d);
    logic c;
    c = en != 0 && !d[0];
    if ((d[2] || c) && !thr_empty) thre_p = 1;
    acc(1'b1, 3'h2, d, 1'b1);
    chk({6'h0, tx_fifo_clear, rx_fifo_clear}, {6'h0, d[2] | c, d[1] | c});
    chk({7'h0, fifo_enable}, {7'h0, d[0]});
    en = d[0];
    trig = d[7:6];
    @(negedge clk_sys);
    chk({6'h0, tx_fifo_clear, rx_fifo_clear}, 8'h00);
  endtask : wf

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {io_rd, io_wr, divisor_latch_access_bit, modem_change, modem_status_read} = '0;
    {line_event, line_status_read, thr_write, push_rx} = '0;
    io_base = 16'h02f8;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    lfsr = 32'hb71d_edb7;
    {interrupt_enable, line_p, modem_p, thre_p} = '0;
    en = 1;
    trig = 3;
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk({7'h0, fifo_enable}, 8'h01);
    chk_id();
    acc(1'b0, 3'h3, 8'h00, 1'b0);
    // Divisor latch hides the enable register
    wi(8'h0f);
    divisor_latch_access_bit = 1'b1;
    wi(8'h00);
    chk(io_rdata, 8'h0f);
    divisor_latch_access_bit = 1'b0;
    acc(1'b0, 3'h1, 8'h00, 1'b1);
    chk(io_rdata, 8'h0f);
    // Reset trigger of 14 bytes: one byte raises nothing
    pulse(push_rx);
    chk_id();
    // All four sources at once, released in priority order
    pulse(line_event);
    line_p = 1;
    pulse(modem_change);
    modem_p = 1;
    wf(8'h01);
    pulse(push_rx);
    wf(8'h05);
    repeat (2) @(negedge clk_sys);
    chk_id();
    pulse(line_status_read);
    line_p = 0;
    chk_id();
    wf(8'h03);
    chk_id();
    chk_id();
    pulse(modem_status_read);
    modem_p = 0;
    chk_id();
    // Every trigger level, byte by byte
    for (int t = 0; t < 4; t++) begin
      wf({t[1:0], 6'h03});
      for (int b = 0; b < 15; b++) begin
        pulse(push_rx);
        chk_id();
      end
    end
    // FIFOs off, then random enables
    wf(8'h00);
    chk_id();
    pulse(push_rx);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      wi(lfsr[7:0]);
      chk_id();
    end
    // Holding buffer written, then emptied again by a transmit clear
    wi(8'h02);
    chk_id();
    pulse(thr_write);
    thre_p = 0;
    chk_id();
    wf(8'h04);
    chk_id();
    end_of_test();
  end
endmodule : uart_interrupt_fifo_control_tb_top
